// ---- rtl/rx_path_pkg.sv ----
// Shared constants and types for the quad receive digital path
//
// Contract
// [RQ1] Without input signal the receive clock free-runs at reference/16 or reference rate; the code's fast option toggles every clock, reference/2.
// [RQ2] Receive clock always toggles with duty cycle held near 50 percent.
// [RQ3] Data latency is about 1 to 14 bit periods, depending on decoding.
// [RQ4] All twelve loopback controls set: recovery bypassed, raw RZ rails passed out.
// [RQ5] Any other loopback combination: recovered clock with retimed rail data.
// [RQ6] Zero-substitution decoding per channel, single-rail only, when code select high.
// [RQ7] Decoding selection also enables matching transmit encoding on that channel.
// [RQ8] Decoded data and code violations, or raw data and bipolar violations.
// [RQ9] Polarity select: 0 active-low, 1 active-high data.
// [RQ10] Retiming edge select: 1 rising, 0 falling receive clock edge.
// [RQ11] Long analog-loss timer declares loss 1 to 2.6 ms after loss.
// [RQ12] Short analog-loss timer declares loss 10 to 255 bit periods after loss.
// [RQ13] Outside logic keeps the short timer off in DS1 operation.
// [RQ14] DS1: digital loss raised after 100 or more consecutive zeros.
// [RQ15] DS1: digital loss cleared at 12.5 percent ones over 100 positions.
// [RQ16] DS1 with loss standard 1: also fewer than 15 consecutive zeros.
// [RQ17] CEPT: raise at 255 zeros, clear at 12.5 percent over 255.
// [RQ18] No shutdown, no AIS: analog loss forces inactive rails, free-running clock.
// [RQ19] AIS without shutdown: either loss sends all ones on free-running clock.
// [RQ20] Shutdown: either loss forces inactive rails and free-running clock.
// [RQ21] Any loopback active: outputs untouched by shutdown or AIS policy.
// [RQ22] Violations only in single rail: same-polarity ones or code violations.
// [RQ23] Rail mode 0 single-rail data and violation, 1 dual-rail pos and neg.
// [RQ24] Violation output uses the active level from polarity select.
// [RQ25] Each channel runs its own decoding, loss detection and output policy.
package rx_path_pkg;

    localparam int NCH = 4;

    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] CODE_OFS = 8'h04;
    localparam logic [7:0] LOOP_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS = 8'h0c;

    typedef struct packed {
        logic receive_jitter_atten_enable;
        logic receive_ais_select;
        logic loss_shutdown_select;
        logic loss_standard_select;
        logic analog_loss_timer_select;
        logic cept_mode;
        logic free_run_clock_select;
        logic retiming_edge_select;
        logic polarity_select;
        logic dual_rail;
    } ctrl_t;

    typedef struct packed {
        logic [3:0] digital_local_loop_ctl;
        logic [3:0] remote_loop_ctl;
        logic [3:0] full_local_loop_ctl;
    } loop_t;

    typedef struct packed {
        logic kill;
        logic viol;
        logic neg;
        logic pos;
    } sym_t;

    localparam logic [9:0]  CTRL_RST = 10'h006;
    localparam logic [3:0]  CODE_RST = 4'h0;
    localparam logic [11:0] LOOP_RST = 12'h000;

    // Bit period is 16 reference clocks
    localparam logic [3:0] PH_LAST = 4'hf;
    localparam logic [3:0] PH_RISE = 4'h0;
    localparam logic [3:0] PH_FALL = 4'h8;
    localparam logic [3:0] PH_ADJ  = 4'hc;
    localparam int         BIT_CYC = 16;

    localparam int CLK_MHZ          = 250;
    localparam int ANALOG_LOSS_ALARM_LONG_US     = 1000;
    localparam int ANALOG_LOSS_ALARM_LONG_CYC    = ANALOG_LOSS_ALARM_LONG_US * CLK_MHZ;
    localparam logic [17:0] ANALOG_LOSS_ALARM_SHORT_BITS = 18'h00020;

    localparam logic [7:0] DS1_ZLIM   = 8'h64;
    localparam logic [7:0] CEPT_ZLIM  = 8'hff;
    localparam logic [7:0] DS1_ONES   = 8'h0d;
    localparam logic [7:0] CEPT_ONES  = 8'h20;
    localparam logic [7:0] STD_MAXZ   = 8'h0f;

endpackage : rx_path_pkg

// ---- rtl/rx_path_top.sv ----
// Quad receive digital path: recovery, decoding, loss alarms, output policy
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
module rx_path_top #(
    parameter int ANALOG_LOSS_ALARM_LONG_CYC = rx_path_pkg::ANALOG_LOSS_ALARM_LONG_CYC
) (
    input  wire logic        CLOCK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [7:0]  PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic [3:0]  SLICER_POS,
    input  wire logic [3:0]  SLICER_NEG,
    input  wire logic [3:0]  ANALOG_LOW,
    output logic      [3:0]  RX_CLK,
    output logic      [3:0]  RECEIVE_POSITIVE_RAIL,
    output logic      [3:0]  RECEIVE_NEGATIVE_RAIL,
    output logic      [3:0]  ANALOG_LOSS_ALARM,
    output logic      [3:0]  DIGITAL_LOSS_ALARM,
    output logic      [3:0]  TX_ZERO_SUB_EN
);

    rx_path_pkg::ctrl_t ctrl_q;
    rx_path_pkg::loop_t loop_q;
    logic [3:0]         code_q;
    logic [31:0]        prdata_q;
    logic [3:0]         analog_loss_alarm_w;
    logic [3:0]         digital_loss_alarm_w;
    logic               bypass;

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == rx_path_pkg::CTRL_OFS) || (a == rx_path_pkg::CODE_OFS) ||
                   (a == rx_path_pkg::LOOP_OFS) || (a == rx_path_pkg::STAT_OFS);
    endfunction : addr_hit

    function automatic logic act(input logic pol, input logic x);
        act = pol ? x : ~x;
    endfunction : act

    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= rx_path_pkg::CTRL_RST;
            code_q <= rx_path_pkg::CODE_RST;
            loop_q <= rx_path_pkg::LOOP_RST;
        end else if (PSEL && PENABLE && PWRITE) begin
            unique case (PADDR)
                rx_path_pkg::CTRL_OFS: ctrl_q <= PWDATA[9:0];
                rx_path_pkg::CODE_OFS: code_q <= PWDATA[3:0];
                rx_path_pkg::LOOP_OFS: loop_q <= PWDATA[11:0];
                default: ;
            endcase
        end
    end

    // Read data is latched in the setup phase so the zero-wait access sees it
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_q <= 32'h0000_0000;
        end else if (PSEL && !PENABLE) begin
            unique case (PADDR)
                rx_path_pkg::CTRL_OFS: prdata_q <= {22'h000000, ctrl_q};
                rx_path_pkg::CODE_OFS: prdata_q <= {28'h0000000, code_q};
                rx_path_pkg::LOOP_OFS: prdata_q <= {20'h00000, loop_q};
                rx_path_pkg::STAT_OFS: prdata_q <= {24'h000000, digital_loss_alarm_w, analog_loss_alarm_w};
                default:               prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign PRDATA  = prdata_q;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !addr_hit(PADDR);

    assign bypass = &{loop_q.full_local_loop_ctl, loop_q.remote_loop_ctl,
                      loop_q.digital_local_loop_ctl};                            // [RQ4]

    assign TX_ZERO_SUB_EN = code_q & {4{~ctrl_q.dual_rail}};                     // [RQ7]

    // Independent logic per channel [RQ25]
    for (genvar ch = 0; ch < rx_path_pkg::NCH; ch++) begin : g_ch
        logic [2:0]        s1_q, s2_q, s3_q, f_q;
        logic              mark_d1_q;
        logic [3:0]        phase_q;
        logic [1:0]        adj_q;
        logic              fast_q;
        logic              pos_seen_q, neg_seen_q, last_pol_q;
        rx_path_pkg::sym_t [7:0] win_q;
        rx_path_pkg::sym_t [7:0] cand;
        rx_path_pkg::sym_t nsym, tap;
        logic              b8zs_hit, hdb3_hit;
        logic              hold_a_q, hold_b_q;
        logic [17:0]       analog_loss_alarm_cnt_q;
        logic              analog_loss_alarm_q;
        logic [7:0]        zrun_q, blk_q, ones_q, maxz_q;
        logic              digital_loss_alarm_q;
        logic              stb, decode, loop_any, alarm, free_run;
        logic [7:0]        zlim, ones_thr;
        logic [17:0]       analog_loss_alarm_tgt;
        logic              rpos_q, rneg_q, rclk_q;

        // Three-stage pin synchroniser; a change counts once stages 2 and 3 agree
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                s1_q <= 3'h0;
                s2_q <= 3'h0;
                s3_q <= 3'h0;
                f_q  <= 3'h0;
            end else begin
                s1_q <= {ANALOG_LOW[ch], SLICER_NEG[ch], SLICER_POS[ch]};
                s2_q <= s1_q;
                s3_q <= s2_q;
                for (int i = 0; i < 3; i++) begin
                    if (s2_q[i] == s3_q[i]) begin
                        f_q[i] <= s3_q[i];
                    end
                end
            end
        end

        assign stb      = (phase_q == rx_path_pkg::PH_LAST);
        assign decode   = code_q[ch] && !ctrl_q.dual_rail;                          // [RQ6]
        assign loop_any = loop_q.full_local_loop_ctl[ch] | loop_q.remote_loop_ctl[ch] |
                          loop_q.digital_local_loop_ctl[ch];
        assign alarm    = analog_loss_alarm_q | digital_loss_alarm_q;
        assign free_run = !loop_any && (analog_loss_alarm_q ||
                          (alarm && (ctrl_q.loss_shutdown_select ||
                                     ctrl_q.receive_ais_select)));                 // [RQ18] [RQ19] [RQ20]

        // Digital PLL; phase nudged by one count in the low half only [RQ2]
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                mark_d1_q <= 1'b0;
                adj_q     <= 2'h0;
                phase_q   <= 4'h0;
                fast_q    <= 1'b0;
            end else begin
                mark_d1_q <= f_q[0] | f_q[1];
                fast_q    <= ~fast_q;
                if ((f_q[0] | f_q[1]) && !mark_d1_q && !free_run &&
                    phase_q != rx_path_pkg::PH_RISE) begin                         // [RQ5]
                    adj_q <= phase_q[3] ? 2'h2 : 2'h1;
                end else if (phase_q == rx_path_pkg::PH_ADJ) begin
                    adj_q <= 2'h0;
                end
                if (phase_q == rx_path_pkg::PH_ADJ && adj_q == 2'h1) begin
                    phase_q <= phase_q;
                end else if (phase_q == rx_path_pkg::PH_ADJ && adj_q == 2'h2) begin
                    phase_q <= phase_q + 4'h2;
                end else begin
                    phase_q <= phase_q + 4'h1;                                     // [RQ1]
                end
            end
        end

        // Line symbol of the bit just ending; violation = same polarity as last mark
        always_comb begin
            nsym      = '0;
            nsym.pos  = pos_seen_q | f_q[0];
            nsym.neg  = !nsym.pos && (neg_seen_q | f_q[1]);
            nsym.viol = (nsym.pos && last_pol_q) || (nsym.neg && !last_pol_q);       // [RQ22]
            cand      = {win_q[6:0], nsym};
            b8zs_hit  = 1'b1;
            hdb3_hit  = 1'b1;
            for (int i = 0; i < 8; i++) begin
                if (i == 7 || i == 6 || i == 5 || i == 2) begin
                    b8zs_hit = b8zs_hit && !cand[i].pos && !cand[i].neg;
                end else if (i == 4 || i == 1) begin
                    b8zs_hit = b8zs_hit && cand[i].viol;
                end else begin
                    b8zs_hit = b8zs_hit && (cand[i].pos | cand[i].neg) && !cand[i].viol;
                end
            end
            hdb3_hit = cand[0].viol && !(cand[1].pos | cand[1].neg) &&
                       !(cand[2].pos | cand[2].neg) && !cand[3].viol;
            b8zs_hit = b8zs_hit && !ctrl_q.cept_mode;
            hdb3_hit = hdb3_hit && ctrl_q.cept_mode;
            for (int i = 0; i < 8; i++) begin
                if ((b8zs_hit) || (hdb3_hit && i < 4)) begin
                    cand[i].kill = 1'b1;
                end
            end
        end

        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                pos_seen_q <= 1'b0;
                neg_seen_q <= 1'b0;
                last_pol_q <= 1'b0;
                win_q      <= '0;
            end else if (stb) begin
                pos_seen_q <= 1'b0;
                neg_seen_q <= 1'b0;
                win_q      <= cand;
                if (nsym.pos | nsym.neg) begin
                    last_pol_q <= nsym.pos;
                end
            end else begin
                pos_seen_q <= pos_seen_q | f_q[0];
                neg_seen_q <= neg_seen_q | f_q[1];
            end
        end

        // Decoding taps the end of the window; raw data the front [RQ3]
        assign tap = decode ? win_q[7] : win_q[0];

        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                hold_a_q <= 1'b0;
                hold_b_q <= 1'b0;
            end else if (stb) begin
                if (ctrl_q.dual_rail) begin                                        // [RQ23]
                    hold_a_q <= tap.pos;
                    hold_b_q <= tap.neg;
                end else begin
                    hold_a_q <= (tap.pos | tap.neg) && !(decode && tap.kill);      // [RQ8]
                    hold_b_q <= tap.viol && !(decode && tap.kill);                 // [RQ8] [RQ22]
                end
            end
        end

        // Analog loss timer, cleared as soon as the signal returns
        assign analog_loss_alarm_tgt = ctrl_q.analog_loss_timer_select ? rx_path_pkg::ANALOG_LOSS_ALARM_SHORT_BITS
                                                          : 18'(ANALOG_LOSS_ALARM_LONG_CYC);
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                analog_loss_alarm_cnt_q <= 18'h00000;
                analog_loss_alarm_q     <= 1'b0;
            end else if (!f_q[2]) begin
                analog_loss_alarm_cnt_q <= 18'h00000;
                analog_loss_alarm_q     <= 1'b0;
            end else if (analog_loss_alarm_cnt_q >= analog_loss_alarm_tgt) begin
                analog_loss_alarm_q <= 1'b1;                                                    // [RQ11] [RQ12]
            end else if (!ctrl_q.analog_loss_timer_select || stb) begin
                analog_loss_alarm_cnt_q <= analog_loss_alarm_cnt_q + 18'h00001;
            end
        end

        // Digital loss: zero run raises, block ones density clears
        assign zlim     = ctrl_q.cept_mode ? rx_path_pkg::CEPT_ZLIM : rx_path_pkg::DS1_ZLIM;
        assign ones_thr = ctrl_q.cept_mode ? rx_path_pkg::CEPT_ONES : rx_path_pkg::DS1_ONES;
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                zrun_q <= 8'h00;
                blk_q  <= 8'h00;
                ones_q <= 8'h00;
                maxz_q <= 8'h00;
                digital_loss_alarm_q <= 1'b0;
            end else if (stb) begin
                if (nsym.pos | nsym.neg) begin
                    zrun_q <= 8'h00;
                end else if (zrun_q != 8'hff) begin
                    zrun_q <= zrun_q + 8'h01;
                end
                if (!(nsym.pos | nsym.neg) && zrun_q + 8'h01 >= zlim) begin
                    digital_loss_alarm_q <= 1'b1;                                                // [RQ14] [RQ17]
                    blk_q  <= 8'h00;
                    ones_q <= 8'h00;
                    maxz_q <= 8'h00;
                end else if (digital_loss_alarm_q) begin
                    if (blk_q + 8'h01 >= zlim) begin
                        digital_loss_alarm_q <= !((ones_q + 8'(nsym.pos | nsym.neg) >= ones_thr) &&
                                  (ctrl_q.cept_mode || !ctrl_q.loss_standard_select ||
                                   maxz_q < rx_path_pkg::STD_MAXZ));               // [RQ15] [RQ16] [RQ17]
                        blk_q  <= 8'h00;
                        ones_q <= 8'h00;
                        maxz_q <= 8'h00;
                    end else begin
                        blk_q  <= blk_q + 8'h01;
                        ones_q <= ones_q + 8'(nsym.pos | nsym.neg);
                        if (!(nsym.pos | nsym.neg) && zrun_q + 8'h01 > maxz_q) begin
                            maxz_q <= zrun_q + 8'h01;
                        end
                    end
                end
            end
        end

        // Output stage with retiming edge, polarity and alarm policy
        always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N) begin
                rpos_q <= 1'b0;
                rneg_q <= 1'b0;
                rclk_q <= 1'b0;
            end else begin
                rclk_q <= (free_run && ctrl_q.free_run_clock_select) ? fast_q
                                                                     : !phase_q[3]; // [RQ1] [RQ2]
                if (bypass) begin
                    rpos_q <= act(ctrl_q.polarity_select, f_q[0]);                 // [RQ4]
                    rneg_q <= act(ctrl_q.polarity_select, f_q[1]);
                end else if (!loop_any && alarm && ctrl_q.loss_shutdown_select) begin
                    rpos_q <= act(ctrl_q.polarity_select, 1'b0);                   // [RQ20]
                    rneg_q <= act(ctrl_q.polarity_select, 1'b0);
                end else if (!loop_any && alarm && ctrl_q.receive_ais_select) begin
                    rpos_q <= act(ctrl_q.polarity_select, 1'b1);                   // [RQ19]
                    rneg_q <= act(ctrl_q.polarity_select, 1'b1);
                end else if (!loop_any && analog_loss_alarm_q) begin
                    rpos_q <= act(ctrl_q.polarity_select, 1'b0);                   // [RQ18]
                    rneg_q <= act(ctrl_q.polarity_select, 1'b0);
                end else if (phase_q == (ctrl_q.retiming_edge_select ? rx_path_pkg::PH_RISE
                                                                     : rx_path_pkg::PH_FALL)) begin
                    rpos_q <= act(ctrl_q.polarity_select, hold_a_q);               // [RQ9] [RQ10] [RQ21]
                    rneg_q <= act(ctrl_q.polarity_select, hold_b_q);               // [RQ24]
                end
            end
        end

        assign RX_CLK[ch]                = rclk_q;
        assign RECEIVE_POSITIVE_RAIL[ch] = rpos_q;
        assign RECEIVE_NEGATIVE_RAIL[ch] = rneg_q;
        assign analog_loss_alarm_w[ch]                = analog_loss_alarm_q;
        assign digital_loss_alarm_w[ch]                = digital_loss_alarm_q;
    end

    assign ANALOG_LOSS_ALARM  = analog_loss_alarm_w;
    assign DIGITAL_LOSS_ALARM = digital_loss_alarm_w;

endmodule : rx_path_top

// ---- test/line_source.sv ----
// Line-side model sending AMI return-to-zero slicer pulses per channel
`timescale 1ns/100ps
module line_source (
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] mark_en,
    output logic      [3:0] pos,
    output logic      [3:0] neg
);
    logic [3:0] ph_q;
    logic [3:0] alt_q;
    logic [3:0] en_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ph_q  <= 4'h0;
            alt_q <= 4'h0;
            en_q  <= 4'h0;
        end else begin
            ph_q <= ph_q + 4'h1;
            if (ph_q == 4'hf) begin
                alt_q <= alt_q ^ en_q;
                en_q  <= mark_en;
            end
        end
    end
    // Marks alternate polarity, pulse early in the bit, line idles at zero
    assign pos = (ph_q > 4'h0 && ph_q < 4'h4) ? (en_q & ~alt_q) : 4'h0;
    assign neg = (ph_q > 4'h0 && ph_q < 4'h4) ? (en_q & alt_q) : 4'h0;
endmodule : line_source

// ---- test/rx_path_asserts.sv ----
// Port-level assertions for the quad receive path
`timescale 1ns/100ps
module rx_path_asserts (
    input wire logic       CLOCK,
    input wire logic       RST_N,
    input wire logic       PSEL,
    input wire logic       PENABLE,
    input wire logic       PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic       PREADY,
    input wire logic       PSLVERR,
    input wire logic [3:0] ANALOG_LOW,
    input wire logic [3:0] RX_CLK,
    input wire logic [3:0] ANALOG_LOSS_ALARM,
    input wire logic [3:0] DIGITAL_LOSS_ALARM,
    input wire logic [3:0] TX_ZERO_SUB_EN
);
    default clocking @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);

    // Cycles since the channel 0 receive clock last changed
    logic [4:0] still_q;
    always_ff @(posedge CLOCK or negedge RST_N) begin
        if (!RST_N)
            still_q <= 5'h00;
        else if ($changed(RX_CLK[0]))
            still_q <= 5'h00;
        else
            still_q <= still_q + 5'h01;
    end

    pready_zero_wait_a: assert property (PSEL && PENABLE |-> PREADY)
        else $error("ready low in access phase");
    slverr_unmapped_a: assert property (PSEL && PENABLE && PADDR > 8'h0c |-> PSLVERR)
        else $error("no error on unmapped access");
    slverr_mapped_a: assert property (PSEL && PENABLE && PADDR[1:0] == 2'h0
        && PADDR <= 8'h0c |-> !PSLVERR) else $error("error on mapped access");
    rxclk_toggle_a: assert property (still_q < 5'h0a)
        else $error("receive clock stopped");
    analog_loss_alarm_cause_a: assert property ($rose(ANALOG_LOSS_ALARM[0]) |->
        $past(ANALOG_LOW[0], 5) && $past(ANALOG_LOW[0], 9)) else $error("alarm without low");
    analog_loss_alarm_release_a: assert property (!ANALOG_LOW[0] [*8] |=> !ANALOG_LOSS_ALARM[0])
        else $error("alarm held after signal return");
    txsub_hold_a: assert property (!(PSEL && PENABLE && PWRITE) |=>
        $stable(TX_ZERO_SUB_EN)) else $error("transmit coding changed without write");
    digital_loss_alarm_per_bit_a: assert property ($changed(DIGITAL_LOSS_ALARM[1]) |=>
        $stable(DIGITAL_LOSS_ALARM[1]) [*8]) else $error("digital alarm chatter");

    cover property ($rose(ANALOG_LOSS_ALARM[0]));
    cover property ($rose(DIGITAL_LOSS_ALARM[1]));
    cover property (PSEL && PENABLE && PSLVERR);
endmodule : rx_path_asserts

bind rx_path_top rx_path_asserts i_rx_path_asserts (
    .CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR), .ANALOG_LOW(ANALOG_LOW),
    .RX_CLK(RX_CLK), .ANALOG_LOSS_ALARM(ANALOG_LOSS_ALARM),
    .DIGITAL_LOSS_ALARM(DIGITAL_LOSS_ALARM), .TX_ZERO_SUB_EN(TX_ZERO_SUB_EN)
);

// ---- test/tb_top.sv ----
// Self-checking bench for the quad receive path
`timescale 1ns/100ps
module tb_top;
    logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, err, p;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  mark_en, spos, sneg, alow, rclk, rpos, rneg, analog_loss_alarm, digital_loss_alarm, txsub;
    int          bad_count, samples_checked, miss, tog;

    rx_path_top #(.ANALOG_LOSS_ALARM_LONG_CYC(200)) i_rx_path_top (
        .CLOCK(clock), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SLICER_POS(spos), .SLICER_NEG(sneg), .ANALOG_LOW(alow),
        .RX_CLK(rclk), .RECEIVE_POSITIVE_RAIL(rpos), .RECEIVE_NEGATIVE_RAIL(rneg),
        .ANALOG_LOSS_ALARM(analog_loss_alarm), .DIGITAL_LOSS_ALARM(digital_loss_alarm), .TX_ZERO_SUB_EN(txsub)
    );
    line_source i_line_source (
        .clk(clock), .rst_n(rst_n), .mark_en(mark_en), .pos(spos), .neg(sneg)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Idle edge at the end keeps the next setup off this release
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb

    task automatic bits(input int n);
        repeat (n * 16) @(posedge clock);
    endtask : bits

    // Cycles over two bits where a channel's rails differ from exp; clock changes too
    task automatic watch(input int ch, input logic [1:0] exp);
        miss = 0;
        tog = 0;
        p = rclk[ch];
        repeat (32) begin
            @(posedge clock);
            if ({rpos[ch], rneg[ch]} !== exp) miss++;
            if (rclk[ch] !== p) tog++;
            p = rclk[ch];
        end
    endtask : watch

    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl reset", rd, 32'h6);
        apb(1'b1, 8'h0c, 32'hff);
        apb(1'b0, 8'h0c, 32'h0);
        check("stat read only", rd, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b1, 8'h04, 32'h5);
        check("tx coding single", {28'h0, txsub}, 32'h5);
        apb(1'b1, 8'h00, 32'h7);
        check("tx coding dual", {28'h0, txsub}, 32'h0);
        apb(1'b1, 8'h00, 32'h6);
        apb(1'b1, 8'h04, 32'h0);
        $display("test regs done");
    endtask : t_regs

    // Channel 1 silent; DS1 keeps the short timer off
    task automatic t_loss(input logic [31:0] ctrl, input int early, input int late);
        apb(1'b1, 8'h00, ctrl);
        mark_en <= 4'hd;
        bits(early);
        check("digital loss early", {28'h0, digital_loss_alarm}, 32'h0);
        bits(late);
        check("digital loss raised", {28'h0, digital_loss_alarm}, 32'h2);
        mark_en <= 4'hf;
        bits(early == 95 ? 230 : 540);
        check("digital loss cleared", {28'h0, digital_loss_alarm}, 32'h0);
        watch(1, 2'b10);
        check("rail data", miss, ctrl[0] ? 32'h10 : 32'h0);
        $display("test digital loss done");
    endtask : t_loss

    task automatic t_short();
        apb(1'b1, 8'h00, 32'h3e);
        alow <= 4'h1;
        bits(9);
        check("short timer early", {28'h0, analog_loss_alarm}, 32'h0);
        bits(31);
        check("short timer raised", {28'h0, analog_loss_alarm}, 32'h1);
        watch(0, 2'b00);
        check("inactive low rails", miss, 32'h0);
        check("fast free run", tog, 32'h20);
        apb(1'b1, 8'h00, 32'h34);
        bits(1);
        watch(0, 2'b11);
        check("inactive high rails", miss, 32'h0);
        check("slow free run", tog, 32'h4);
        alow <= 4'h0;
        bits(1);
        check("analog loss cleared", {28'h0, analog_loss_alarm}, 32'h0);
        $display("test short timer done");
    endtask : t_short

    task automatic t_policy();
        apb(1'b1, 8'h00, 32'h106);
        alow <= 4'h8;
        mark_en <= 4'hd;
        repeat (190) @(posedge clock);
        check("long timer early", {28'h0, analog_loss_alarm}, 32'h0);
        bits(110);
        check("long timer raised", {28'h0, analog_loss_alarm}, 32'h8);
        watch(3, 2'b11);
        check("ais analog", miss, 32'h0);
        watch(1, 2'b11);
        check("ais digital", miss, 32'h0);
        apb(1'b1, 8'h00, 32'h186);
        bits(1);
        watch(3, 2'b00);
        check("shutdown analog", miss, 32'h0);
        watch(1, 2'b00);
        check("shutdown digital", miss, 32'h0);
        alow <= 4'h0;
        mark_en <= 4'hf;
        apb(1'b1, 8'h08, 32'hfff);
        apb(1'b1, 8'h00, 32'h86);
        alow <= 4'h1;
        bits(40);
        watch(0, 2'b00);
        check("raw pulses pass", {31'h0, miss > 0 && miss < 32}, 32'h1);
        alow <= 4'h0;
        apb(1'b1, 8'h08, 32'h0);
        $display("test output policy done");
    endtask : t_policy

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (50000) @(posedge clock);
        bad_count++;
        $display("Error watchdog expired");
        end_of_test();
    end

    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        alow = 4'h0;
        mark_en = 4'hf;
        bad_count = 0;
        samples_checked = 0;
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_regs();
        t_loss(32'h06, 95, 15);
        apb(1'b1, 8'h04, 32'h2);
        t_loss(32'h12, 240, 30);
        t_loss(32'h47, 95, 15);
        t_short();
        t_policy();
        end_of_test();
    end
endmodule : tb_top
